// ===== logic/video_timing_cmd_status_unit.sv
// host command decoder, flag registers and light pen latch of the video timing controller
`timescale 1ns/10ps
`default_nettype none
module video_timing_cmd_status_unit #(
  parameter int ADDR_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host bus
  input wire logic ceN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [2:0] addr,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  // raster timing events
  input wire logic fieldStart,
  input wire logic lineStart,
  input wire logic frontPorchStart,
  input wire logic rowLineZero,
  input wire logic [6:0] rowNumber,
  input wire logic [6:0] splitRowField,
  input wire logic [ADDR_W-1:0] charAddress,
  // raw display outputs from the timing generator
  input wire logic hsyncGen,
  input wire logic vsyncGen,
  input wire logic blankGen,
  input wire logic cursorGen,
  // light pen
  input wire logic lightPenStrobe,
  // delayed command hand-off
  output logic delayedCmdValid,
  output logic [7:0] delayedCmd,
  input wire logic delayedCmdDone,
  // controls
  output logic [3:0] initRegPointer,
  output logic transparentModeSel,
  output logic interruptRequestOut,
  // display pins
  output logic hsyncOut,
  output logic vsyncOut,
  output logic blankOut,
  output logic cursorOut,
  output logic [ADDR_W-1:0] displayAddressBus,
  output logic displayAddressOe
);
  logic busAct_r, busAct_nxt, wasWr_r, wasWr_nxt;
  logic [2:0] addrLat_r, addrLat_nxt;
  logic [7:0] dataLat_r, dataLat_nxt;
  logic [7:0] dataOut_r, dataOut_nxt;
  logic [4:0] statFlags_r, statFlags_nxt;
  logic [4:0] intFlags_r, intFlags_nxt;
  logic [4:0] mask_r, mask_nxt;
  logic cmdReady_r, cmdReady_nxt;
  logic lpEn_r, lpEn_nxt;
  logic [ADDR_W-1:0] lpAddr_r, lpAddr_nxt;
  logic cursorEn_r, cursorEn_nxt;
  logic floatAddr_r, floatAddr_nxt;
  logic syncHold_r, syncHold_nxt;
  logic transparent_r, transparent_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic dlyValid_r, dlyValid_nxt;
  logic [7:0] dlyCmd_r, dlyCmd_nxt;
  logic [ADDR_W-1:0] dispAddr_r, dispAddr_nxt;
  vtc_cmd_pkg::disp_state_t disp_r, disp_nxt;

  logic busNow, wrEnd, rdEnd, cmdWr;
  logic [4:0] events, clrSel;
  logic [15:0] lpWide;

  assign busNow = !ceN && (!rdN || !wrN);
  // act on the trailing edge so the data byte is already stable
  assign wrEnd = busAct_r && !busNow && wasWr_r;
  assign rdEnd = busAct_r && !busNow && !wasWr_r;
  assign cmdWr = wrEnd && addrLat_r == vtc_cmd_pkg::ADDR_CMD;
  // pen bytes read as zero above the address width
  assign lpWide = 16'(lpAddr_r);

  always_comb begin
    events = '0;
    events[vtc_cmd_pkg::FLAG_VERTICAL_BLANK_FLAG] = frontPorchStart;
    events[vtc_cmd_pkg::FLAG_LINE0] = rowLineZero;
    events[vtc_cmd_pkg::FLAG_SPLIT] = rowLineZero && rowNumber == splitRowField;
    events[vtc_cmd_pkg::FLAG_READY] = delayedCmdDone;
    // one load per pen flag, relocked until the pen flag is cleared by a pen byte read or a flag clearing command
    events[vtc_cmd_pkg::FLAG_LPEN] = lpEn_r && lightPenStrobe
      && !statFlags_r[vtc_cmd_pkg::FLAG_LPEN];
  end

  // keep address and data from the strobe, used once it ends
  always_comb begin
    busAct_nxt = busNow;
    wasWr_nxt = busNow ? !wrN : wasWr_r;
    addrLat_nxt = busNow ? addr : addrLat_r;
    dataLat_nxt = (busNow && !wrN) ? dataIn : dataLat_r;
    dispAddr_nxt = charAddress;
  end

  always_comb begin
    statFlags_nxt = statFlags_r;
    intFlags_nxt = intFlags_r;
    mask_nxt = mask_r;
    cmdReady_nxt = cmdReady_r;
    lpEn_nxt = lpEn_r;
    lpAddr_nxt = lpAddr_r;
    cursorEn_nxt = cursorEn_r;
    floatAddr_nxt = floatAddr_r;
    syncHold_nxt = syncHold_r;
    transparent_nxt = transparent_r;
    ptr_nxt = ptr_r;
    disp_nxt = disp_r;
    dlyValid_nxt = 1'b0;
    dlyCmd_nxt = dlyCmd_r;
    clrSel = '0;
    // clears first, so that a same-cycle event below wins
    if (rdEnd && (addrLat_r == vtc_cmd_pkg::ADDR_LPEN_LO
        || addrLat_r == vtc_cmd_pkg::ADDR_LPEN_HI)) begin
      clrSel[vtc_cmd_pkg::FLAG_LPEN] = 1'b1;
    end
    if (wrEnd && (addrLat_r == vtc_cmd_pkg::ADDR_SSTART_LO
        || addrLat_r == vtc_cmd_pkg::ADDR_SSTART_HI)) begin
      clrSel[vtc_cmd_pkg::FLAG_SPLIT] = 1'b1;
    end
    if (cmdWr) begin
      if (dataLat_r == vtc_cmd_pkg::CMD_MASTER_RESET) begin
        clrSel = '1;
        mask_nxt = '0;
        cmdReady_nxt = 1'b1;
        lpEn_nxt = 1'b0;
        cursorEn_nxt = 1'b0;
        floatAddr_nxt = 1'b0;
        transparent_nxt = 1'b1;
        ptr_nxt = vtc_cmd_pkg::PTR_RESET;
        syncHold_nxt = 1'b1;
        disp_nxt = vtc_cmd_pkg::DISP_OFF;
      end else if (dataLat_r[7:4] == vtc_cmd_pkg::CMD_LOAD_PTR_HI) begin
        // out of range values are dropped rather than wrapped
        if (dataLat_r[3:0] <= 4'(vtc_cmd_pkg::PTR_MAX)) begin
          ptr_nxt = dataLat_r[3:0];
        end
      end else if (dataLat_r == vtc_cmd_pkg::CMD_LPEN_ON) begin
        lpEn_nxt = 1'b1;
      end else if (dataLat_r == vtc_cmd_pkg::CMD_LPEN_OFF) begin
        lpEn_nxt = 1'b0;
      end else if ((dataLat_r & vtc_cmd_pkg::CMD_DISP_MASK) == vtc_cmd_pkg::CMD_DISP_OFF) begin
        disp_nxt = vtc_cmd_pkg::DISP_OFF;
        floatAddr_nxt = dataLat_r[vtc_cmd_pkg::OPT_BIT];
      end else if ((dataLat_r & vtc_cmd_pkg::CMD_DISP_MASK) == vtc_cmd_pkg::CMD_DISP_ON) begin
        floatAddr_nxt = 1'b0;
        syncHold_nxt = 1'b0;
        disp_nxt = dataLat_r[vtc_cmd_pkg::OPT_BIT] ? vtc_cmd_pkg::DISP_WAIT_FIELD
          : vtc_cmd_pkg::DISP_WAIT_LINE;
      end else if (dataLat_r == vtc_cmd_pkg::CMD_CURS_OFF) begin
        cursorEn_nxt = 1'b0;
      end else if (dataLat_r == vtc_cmd_pkg::CMD_CURS_ON) begin
        cursorEn_nxt = 1'b1;
      end else if (dataLat_r[7:5] == vtc_cmd_pkg::CMD_RESET_FLAGS) begin
        clrSel = dataLat_r[4:0];
      end else if (dataLat_r[7:5] == vtc_cmd_pkg::CMD_INT_ENABLE) begin
        clrSel = dataLat_r[4:0];
        mask_nxt = mask_r | dataLat_r[4:0];
      end else if (dataLat_r[7:5] == vtc_cmd_pkg::CMD_INT_DISABLE) begin
        mask_nxt = mask_r & ~dataLat_r[4:0];
      end else if (dataLat_r[7:5] == vtc_cmd_pkg::CMD_DELAYED_HI
          || dataLat_r[7:6] == 2'h3) begin
        // busy until the buffer logic reports completion
        dlyValid_nxt = 1'b1;
        dlyCmd_nxt = dataLat_r;
        cmdReady_nxt = 1'b0;
      end
    end
    statFlags_nxt = (statFlags_nxt & ~clrSel) | events;
    // masks gate only the interrupt copy, status sees every event
    intFlags_nxt = (intFlags_nxt & ~clrSel) | (events & mask_nxt);
    // completion applied last so it beats a same-cycle busy
    if (delayedCmdDone) begin
      cmdReady_nxt = 1'b1;
    end
    if (events[vtc_cmd_pkg::FLAG_LPEN]) begin
      lpAddr_nxt = charAddress;
    end
    case (disp_r)
      vtc_cmd_pkg::DISP_WAIT_FIELD: if (fieldStart && disp_nxt == disp_r) begin
        disp_nxt = vtc_cmd_pkg::DISP_ON;
      end
      vtc_cmd_pkg::DISP_WAIT_LINE: if (lineStart && disp_nxt == disp_r) begin
        disp_nxt = vtc_cmd_pkg::DISP_ON;
      end
      vtc_cmd_pkg::DISP_ON, vtc_cmd_pkg::DISP_OFF: ;
      default: disp_nxt = vtc_cmd_pkg::DISP_OFF;
    endcase
  end

  // read data registered, host takes it a cycle into the read
  always_comb begin
    dataOut_nxt = dataOut_r;
    if (busNow && !rdN) begin
      case (addr)
        vtc_cmd_pkg::ADDR_INT_FLAGS: dataOut_nxt = {3'h0, intFlags_r};
        vtc_cmd_pkg::ADDR_STAT_FLAGS: dataOut_nxt = {2'h0, cmdReady_r, statFlags_r};
        vtc_cmd_pkg::ADDR_LPEN_LO: dataOut_nxt = lpWide[7:0];
        vtc_cmd_pkg::ADDR_LPEN_HI: dataOut_nxt = lpWide[15:8];
        default: dataOut_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // power-up leaves the same modes, pointer, masks and flags as a master reset
      busAct_r <= 1'b0;
      wasWr_r <= 1'b0;
      addrLat_r <= 3'h0;
      dataLat_r <= 8'h00;
      dataOut_r <= 8'h00;
      statFlags_r <= vtc_cmd_pkg::FLAGS_RESET;
      intFlags_r <= vtc_cmd_pkg::FLAGS_RESET;
      mask_r <= vtc_cmd_pkg::FLAGS_RESET;
      cmdReady_r <= 1'b1;
      lpEn_r <= 1'b0;
      lpAddr_r <= '0;
      cursorEn_r <= 1'b0;
      floatAddr_r <= 1'b0;
      syncHold_r <= 1'b1;
      transparent_r <= 1'b1;
      ptr_r <= vtc_cmd_pkg::PTR_RESET;
      disp_r <= vtc_cmd_pkg::DISP_OFF;
      dlyValid_r <= 1'b0;
      dlyCmd_r <= 8'h00;
      dispAddr_r <= '0;
    end else begin
      busAct_r <= busAct_nxt;
      wasWr_r <= wasWr_nxt;
      addrLat_r <= addrLat_nxt;
      dataLat_r <= dataLat_nxt;
      dataOut_r <= dataOut_nxt;
      statFlags_r <= statFlags_nxt;
      intFlags_r <= intFlags_nxt;
      mask_r <= mask_nxt;
      cmdReady_r <= cmdReady_nxt;
      lpEn_r <= lpEn_nxt;
      lpAddr_r <= lpAddr_nxt;
      cursorEn_r <= cursorEn_nxt;
      floatAddr_r <= floatAddr_nxt;
      syncHold_r <= syncHold_nxt;
      transparent_r <= transparent_nxt;
      ptr_r <= ptr_nxt;
      disp_r <= disp_nxt;
      dlyValid_r <= dlyValid_nxt;
      dlyCmd_r <= dlyCmd_nxt;
      dispAddr_r <= dispAddr_nxt;
    end
  end

  assign dataOut = dataOut_r;
  assign dataOe = busNow && !rdN;
  assign delayedCmdValid = dlyValid_r;
  assign delayedCmd = dlyCmd_r;
  assign initRegPointer = ptr_r;
  assign transparentModeSel = transparent_r;
  assign interruptRequestOut = |(intFlags_r & mask_r);
  // syncs stay low from master reset until display is switched back on
  assign hsyncOut = hsyncGen && !syncHold_r;
  assign vsyncOut = vsyncGen && !syncHold_r;
  // blank forced until the display-on wait has seen its edge
  assign blankOut = blankGen || disp_r != vtc_cmd_pkg::DISP_ON;
  assign cursorOut = cursorGen && cursorEn_r;
  assign displayAddressBus = dispAddr_r;
  assign displayAddressOe = !floatAddr_r;
endmodule
`default_nettype wire

// ===== logic/vtc_cmd_pkg.sv
// constants for the video timing command and status unit
`default_nettype none
package vtc_cmd_pkg;
  // bus addresses
  localparam logic [2:0] ADDR_INT_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_STAT_FLAGS = 3'h1;
  localparam logic [2:0] ADDR_CMD = 3'h2;
  localparam logic [2:0] ADDR_LPEN_LO = 3'h3;
  localparam logic [2:0] ADDR_LPEN_HI = 3'h4;
  localparam logic [2:0] ADDR_SSTART_LO = 3'h5;
  localparam logic [2:0] ADDR_SSTART_HI = 3'h6;
  // flag register bit positions, command option bit and pointer limit
  localparam int FLAG_LPEN = 0;
  localparam int FLAG_READY = 1;
  localparam int FLAG_SPLIT = 2;
  localparam int FLAG_LINE0 = 3;
  localparam int FLAG_VERTICAL_BLANK_FLAG = 4;
  localparam int FLAG_CMDRDY = 5;
  localparam int OPT_BIT = 2;
  localparam int PTR_MAX = 10;
  // command byte codes
  localparam logic [7:0] CMD_MASTER_RESET = 8'h00;
  localparam logic [3:0] CMD_LOAD_PTR_HI = 4'h1;
  localparam logic [7:0] CMD_LPEN_OFF = 8'h20;
  localparam logic [7:0] CMD_LPEN_ON = 8'h21;
  localparam logic [7:0] CMD_DISP_MASK = 8'hfb;
  localparam logic [7:0] CMD_DISP_OFF = 8'h28;
  localparam logic [7:0] CMD_DISP_ON = 8'h29;
  localparam logic [7:0] CMD_CURS_OFF = 8'h30;
  localparam logic [7:0] CMD_CURS_ON = 8'h31;
  localparam logic [2:0] CMD_RESET_FLAGS = 3'h2;
  localparam logic [2:0] CMD_INT_ENABLE = 3'h3;
  localparam logic [2:0] CMD_INT_DISABLE = 3'h4;
  localparam logic [2:0] CMD_DELAYED_HI = 3'h5;
  // reset values
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] PTR_RESET = 4'h0;
  typedef enum {DISP_OFF, DISP_WAIT_FIELD, DISP_WAIT_LINE, DISP_ON} disp_state_t;
endpackage
`default_nettype wire

// ===== test/host_model.sv
// host processor model on the parallel register bus
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock and read data
  input wire logic clk,
  input wire logic [7:0] dataOut,
  // bus strobes
  output logic ceN,
  output logic rdN,
  output logic wrN,
  output logic [2:0] addr,
  output logic [7:0] dataIn
);
  initial begin
    ceN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    addr = 3'h0;
    dataIn = 8'h00;
  end
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk) {ceN, rdN, addr} = {2'b00, a};
    @(negedge clk) d = dataOut;
    {ceN, rdN} = 2'b11;
    repeat (3) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk) {ceN, wrN, addr, dataIn} = {2'b00, a, d};
    @(negedge clk) {ceN, wrN} = 2'b11;
    // effects land on the first rising edge after the bus goes idle
    repeat (3) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 20 && s[5] !== 1'b1; i++) rd(3'h1, s);
    wr(3'h2, c);
  endtask
  // buffer control 1 is no pin of this block, nothing to hold high
  task automatic mreset;
    cmd(8'h00);
    cmd(8'h00);
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the video timing command and status unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rstn, fieldStart, lineStart, frontPorchStart, rowLineZero, lightPenStrobe;
  logic hsyncGen, vsyncGen, blankGen, cursorGen, delayedCmdDone, ceN, rdN, wrN, dataOe;
  logic delayedCmdValid, transparentModeSel, interruptRequestOut, displayAddressOe;
  logic hsyncOut, vsyncOut, blankOut, cursorOut;
  logic [6:0] rowNumber, splitRowField;
  logic [13:0] charAddress, displayAddressBus;
  logic [2:0] addr;
  logic [7:0] dataIn, dataOut, delayedCmd, seenCmd;
  logic [3:0] initRegPointer;
  int fails, n_tests;
  host_model u_host (.clk, .dataOut, .ceN, .rdN, .wrN, .addr, .dataIn);
  video_timing_cmd_status_unit u_dut (.clk, .rstn, .ceN, .rdN, .wrN, .addr, .dataIn, .dataOut,
    .dataOe, .fieldStart, .lineStart, .frontPorchStart, .rowLineZero, .rowNumber,
    .splitRowField, .charAddress, .hsyncGen, .vsyncGen, .blankGen, .cursorGen, .lightPenStrobe,
    .delayedCmdValid, .delayedCmd, .delayedCmdDone, .initRegPointer, .transparentModeSel,
    .interruptRequestOut, .hsyncOut, .vsyncOut, .blankOut, .cursorOut, .displayAddressBus,
    .displayAddressOe);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the hand-off pulse lasts one cycle, so catch it here
  always @(posedge clk) if (delayedCmdValid === 1'b1) seenCmd <= delayedCmd;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic rs(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic t_reset;
    u_host.mreset;
    rs(3'h1, 8'h20);
    rs(3'h0, 8'h00);
    rs(3'h7, 8'h00);
    chk({blankOut, hsyncOut, vsyncOut, transparentModeSel, initRegPointer}, 8'h90);
  endtask
  task automatic t_events;
    u_host.cmd(8'h7c);
    @(negedge clk) frontPorchStart = 1'b1;
    @(negedge clk) frontPorchStart = 1'b0;
    rs(3'h1, 8'h30);
    rs(3'h0, 8'h10);
    chkb(interruptRequestOut, 1'b1);
    u_host.cmd(8'h50);
    rs(3'h1, 8'h20);
    chkb(interruptRequestOut, 1'b0);
    u_host.cmd(8'h88);
    @(negedge clk) rowLineZero = 1'b1;
    @(negedge clk) rowLineZero = 1'b0;
    rs(3'h1, 8'h2c);
    rs(3'h0, 8'h04);
    u_host.wr(3'h5, 8'h00);
    rs(3'h1, 8'h28);
    rowNumber = 7'h06;
    @(negedge clk) rowLineZero = 1'b1;
    @(negedge clk) rowLineZero = 1'b0;
    rs(3'h1, 8'h28);
    splitRowField = 7'h06;
    @(negedge clk) rowLineZero = 1'b1;
    @(negedge clk) rowLineZero = 1'b0;
    rs(3'h0, 8'h04);
    chkb(interruptRequestOut, 1'b1);
    u_host.wr(3'h6, 8'h00);
    rs(3'h1, 8'h28);
    chkb(interruptRequestOut, 1'b0);
  endtask
  task automatic t_pen;
    u_host.cmd(8'h21);
    @(negedge clk) lightPenStrobe = 1'b1;
    @(negedge clk) lightPenStrobe = 1'b0;
    charAddress = 14'h1111;
    @(negedge clk) lightPenStrobe = 1'b1;
    @(negedge clk) lightPenStrobe = 1'b0;
    rs(3'h1, 8'h29);
    rs(3'h3, 8'h5c);
    rs(3'h4, 8'h2a);
    rs(3'h1, 8'h28);
    u_host.cmd(8'h20);
    @(negedge clk) lightPenStrobe = 1'b1;
    @(negedge clk) lightPenStrobe = 1'b0;
    rs(3'h1, 8'h28);
  endtask
  task automatic t_bus;
    logic [7:0] d;
    fork
      u_host.rd(3'h1, d);
      begin
        repeat (2) @(posedge clk);
        chkb(dataOe, 1'b1);
      end
    join
    chk(d, 8'h28);
    chk(dataOut, 8'h28);
    chkb(dataOe, 1'b0);
    charAddress = 14'h15a3;
    @(negedge clk) chk({2'h0, displayAddressBus[13:8]}, 8'h15);
    chk(displayAddressBus[7:0], 8'ha3);
  endtask
  task automatic t_cmds;
    u_host.cmd(8'h17);
    u_host.cmd(8'h1b);
    chk({4'h0, initRegPointer}, 8'h07);
    u_host.cmd(8'h29);
    chkb(blankOut, 1'b1);
    @(negedge clk) lineStart = 1'b1;
    @(negedge clk) lineStart = 1'b0;
    chk({5'h00, blankOut, hsyncOut, vsyncOut}, 8'h03);
    blankGen = 1'b1;
    @(negedge clk) chkb(blankOut, 1'b1);
    blankGen = 1'b0;
    u_host.cmd(8'h2c);
    chk({6'h00, blankOut, displayAddressOe}, 8'h02);
    u_host.cmd(8'h2d);
    @(negedge clk) lineStart = 1'b1;
    @(negedge clk) lineStart = 1'b0;
    chk({6'h00, blankOut, displayAddressOe}, 8'h03);
    @(negedge clk) fieldStart = 1'b1;
    @(negedge clk) fieldStart = 1'b0;
    chkb(blankOut, 1'b0);
    hsyncGen = 1'b0;
    @(negedge clk) chk({6'h00, hsyncOut, vsyncOut}, 8'h01);
    hsyncGen = 1'b1;
    vsyncGen = 1'b0;
    @(negedge clk) chk({6'h00, hsyncOut, vsyncOut}, 8'h02);
    vsyncGen = 1'b1;
    u_host.cmd(8'h31);
    chkb(cursorOut, 1'b1);
    cursorGen = 1'b0;
    @(negedge clk) chkb(cursorOut, 1'b0);
    cursorGen = 1'b1;
    u_host.cmd(8'h30);
    chkb(cursorOut, 1'b0);
  endtask
  task automatic t_delayed;
    u_host.cmd(8'ha2);
    chk(seenCmd, 8'ha2);
    rs(3'h1, 8'h08);
    @(negedge clk) delayedCmdDone = 1'b1;
    @(negedge clk) delayedCmdDone = 1'b0;
    rs(3'h1, 8'h2a);
    u_host.cmd(8'he9);
    chk(seenCmd, 8'he9);
    @(negedge clk) delayedCmdDone = 1'b1;
    @(negedge clk) delayedCmdDone = 1'b0;
    u_host.cmd(8'h31);
    rs(3'h1, 8'h2a);
    u_host.mreset;
    rs(3'h1, 8'h20);
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    fieldStart = 1'b0;
    lineStart = 1'b0;
    frontPorchStart = 1'b0;
    rowLineZero = 1'b0;
    lightPenStrobe = 1'b0;
    hsyncGen = 1'b1;
    vsyncGen = 1'b1;
    blankGen = 1'b0;
    cursorGen = 1'b1;
    delayedCmdDone = 1'b0;
    rowNumber = 7'h05;
    splitRowField = 7'h05;
    charAddress = 14'h2a5c;
    fails = 0;
    n_tests = 0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_reset;
    t_events;
    t_pen;
    t_bus;
    t_cmds;
    t_delayed;
    wrap_up;
  end
  initial begin
    // the whole sequence needs well under a thousand cycles
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
bind video_timing_cmd_status_unit vtc_cmd_status_asserts u_chk (.clk, .rstn, .ceN, .wrN, .addr,
  .dataIn, .hsyncGen, .vsyncGen, .blankGen, .cursorGen, .hsyncOut, .vsyncOut, .blankOut,
  .cursorOut, .delayedCmdValid, .interruptRequestOut);
`default_nettype wire

// ===== test/vtc_cmd_status_asserts.sv
// port-level checks for the command and status unit
`timescale 1ns/10ps
`default_nettype none
module vtc_cmd_status_asserts (
  // clock, reset, host bus
  input wire logic clk,
  input wire logic rstn,
  input wire logic ceN,
  input wire logic wrN,
  input wire logic [2:0] addr,
  input wire logic [7:0] dataIn,
  // display side
  input wire logic hsyncGen,
  input wire logic vsyncGen,
  input wire logic blankGen,
  input wire logic cursorGen,
  input wire logic hsyncOut,
  input wire logic vsyncOut,
  input wire logic blankOut,
  input wire logic cursorOut,
  // command and interrupt outputs
  input wire logic delayedCmdValid,
  input wire logic interruptRequestOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_sync_gate: assert property ((!hsyncOut || hsyncGen) && (!vsyncOut || vsyncGen))
    else $error("sync out without generator sync");
  a_cursor_gate: assert property (cursorOut |-> cursorGen)
    else $error("cursor out without generator cursor");
  a_blank_pass: assert property (blankGen |-> blankOut)
    else $error("generator blank not passed");
  a_reset_blank: assert property (disable iff (1'b0) !rstn |=> blankOut && !hsyncOut && !vsyncOut)
    else $error("reset did not blank and drop syncs");
  a_reset_irq: assert property (disable iff (1'b0) !rstn |=> !interruptRequestOut)
    else $error("request high after reset");
  a_mreset_cmd: assert property ((!ceN && !wrN && addr == 3'h2 && dataIn == 8'h00) ##1 ceN
    |-> ##[1:3] (blankOut && !hsyncOut && !interruptRequestOut))
    else $error("master reset command had no effect");
  a_dly_issue: assert property ((!ceN && !wrN && addr == 3'h2 && dataIn[7] && (dataIn[6] || dataIn[5]))
    ##1 ceN |-> ##[1:3] delayedCmdValid)
    else $error("delayed command not handed off");
  a_dly_single: assert property (delayedCmdValid |=> !delayedCmdValid)
    else $error("hand-off pulse too long");
  a_dly_after: assert property (delayedCmdValid |-> $past(ceN))
    else $error("hand-off before write ended");
endmodule
`default_nettype wire
